// ### common/fdi_pkg.sv
// Package for the frame delineation and de-interleaver block.
// Assumes a single octet clock domain; all users reference names with fdi_pkg::.
package fdi_pkg;

  // Delineation thresholds
  localparam int unsigned LOCK_HITS = 2;
  localparam int unsigned DROP_VIOL_LOW = 6;
  localparam int unsigned DROP_VIOL_HIGH = 8;
  localparam int unsigned HIGH_RATE_KBPS = 26000;

  // Interleaver limits
  localparam int unsigned MULT_MAX = 64;
  localparam int unsigned RS_T = 8;
  localparam logic [1:0] DIV_BY_4 = 2'h0;
  localparam logic [1:0] DIV_BY_8 = 2'h1;
  localparam logic [1:0] DIV_BY_16 = 2'h2;

  // Reset values
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [1:0] {
    search_state,
    tentative_lock_state,
    locked_state
  } fdi_state_t;

  // Per-position marker observation
  typedef struct packed {
    logic at_expected;
    logic sync_found;
  } fdi_marker_t;

  // Octet stream beat
  typedef struct packed {
    logic valid;
    logic block_start;
    logic [7:0] data;
  } fdi_octet_t;

endpackage

// ### verilog/fdi_deinterleave.sv
// Convolutional de-interleaver: branch j delays by M*I*(I-1-j) octets.
// Assumes octets arrive with a block_start flag on the first octet of each block.
`timescale 1ns/100ps
module fdi_deinterleave #(
  parameter int MAX_I = 16,
  parameter int MEM_DEPTH = 8192
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [4:0] block_len,
  input wire logic [6:0] depth_mult,
  // Stream
  input wire fdi_pkg::fdi_octet_t in_octet,
  output fdi_pkg::fdi_octet_t out_octet
);
  initial begin
    if (MAX_I < 2 || MEM_DEPTH < fdi_pkg::MULT_MAX * MAX_I * (MAX_I - 1))
      $error("fdi_deinterleave: memory too small for block length");
  end

  localparam int AW = $clog2(MEM_DEPTH);
  logic [7:0] mem [MEM_DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [4:0] branch;
  logic [4:0] next_branch;
  logic [AW-1:0] delay;
  logic [AW-1:0] rd_addr;
  fdi_pkg::fdi_octet_t next_out;

  // Block start resynchronises to branch 0 // see RL13
  always_comb begin
    next_branch = branch;
    next_wr_ptr = wr_ptr;
    if (in_octet.valid) begin
      next_wr_ptr = AW'(wr_ptr + 1'b1);
      if (in_octet.block_start || branch >= 5'(block_len - 1'b1))
        next_branch = in_octet.block_start ? 5'd1 : 5'd0;
      else
        next_branch = 5'(branch + 1'b1);
      if (in_octet.block_start && block_len == 5'd1)
        next_branch = 5'd0;
    end
  end

  // Reversed branch delay, one shared ring: the delay seen at branch j is
  // M*I*(I-1-j) octets of stream time // see RL12
  logic [4:0] cur_branch;
  assign cur_branch = in_octet.block_start ? 5'd0 : branch;
  // Widen every factor first: M*I*(I-1) reaches 15360 and would wrap at operand width
  assign delay = AW'(depth_mult) * AW'(block_len) * AW'(5'(block_len - 5'd1 - cur_branch));
  assign rd_addr = AW'(wr_ptr - delay);

  always_comb begin
    next_out = '0;
    next_out.valid = in_octet.valid;
    next_out.block_start = in_octet.valid && cur_branch == 5'd0;
    next_out.data = (delay == '0) ? in_octet.data : mem[rd_addr];
  end

  always_ff @(posedge ref_clk) begin
    if (in_octet.valid)
      mem[wr_ptr] <= in_octet.data;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      branch <= 5'd0;
      out_octet <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      branch <= next_branch;
      out_octet <= next_out;
    end
  end

endmodule // fdi_deinterleave

// ### verilog/fdi_frame_delin.sv
// Receive frame delineation machine plus de-interleaver parameter logic.
// Assumes marker observations and octets come from same-clock framing logic.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1: count hit only on syncword at expected slot
// RL2: search state, first hit goes tentative
// RL3: two consecutive hits in tentative lock
// RL4: one violation in tentative returns search
// RL5: six consecutive violations drop lock
// RL6: above 26 Mbit/s, need eight violations
// RL7: block length is codeword over 4/8/16
// RL8: multiplier 0..64; depth = M*I+1
// RL9: erasure span = floor(8I/S)*depth
// RL10: erasure span is longest repairable burst
// RL11: octet k of each block to branch k
// RL12: de-interleaver delays reverse the interleaver
// RL13: block first octet steered to branch 0
// RL14: reset into search, counters clear, unlocked
module fdi_frame_delin #(
  parameter int MAX_S = 256,
  parameter int unsigned LINE_RATE_KBPS = 12960
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [7:0] codeword_len,
  input wire logic [1:0] block_div,
  input wire logic [6:0] depth_mult,
  // Marker observation
  input wire fdi_pkg::fdi_marker_t marker,
  // Octet stream
  input wire fdi_pkg::fdi_octet_t rx_octet,
  output fdi_pkg::fdi_octet_t dl_octet,
  // Status
  output logic frame_locked,
  output fdi_pkg::fdi_state_t delin_state,
  output logic [4:0] block_len,
  output logic [11:0] depth_octets,
  output logic [15:0] erasure_span,
  output logic cfg_error
);
  initial begin
    if (MAX_S > 256 || MAX_S < 16)
      $error("fdi_frame_delin: MAX_S out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Delineation machine
  localparam logic [3:0] DROP_LIMIT = (LINE_RATE_KBPS > fdi_pkg::HIGH_RATE_KBPS)
    ? 4'(fdi_pkg::DROP_VIOL_HIGH) : 4'(fdi_pkg::DROP_VIOL_LOW); // see RL6
  localparam logic [3:0] HIT_LIMIT = 4'(fdi_pkg::LOCK_HITS);

  fdi_pkg::fdi_state_t state;
  fdi_pkg::fdi_state_t next_state;
  logic [3:0] hits;
  logic [3:0] next_hits;
  logic [3:0] viols;
  logic [3:0] next_viols;
  logic hit;
  logic viol;

  // Only positions flagged as expected count at all // see RL1
  assign hit = marker.at_expected && marker.sync_found;
  assign viol = marker.at_expected && !marker.sync_found;

  always_comb begin
    next_state = state;
    next_hits = hits;
    next_viols = viols;
    unique case (state)
      fdi_pkg::search_state: begin
        next_hits = fdi_pkg::CNT_RESET;
        next_viols = fdi_pkg::CNT_RESET;
        if (hit) begin
          next_state = fdi_pkg::tentative_lock_state; // see RL2
          next_hits = 4'h1;
        end
      end
      fdi_pkg::tentative_lock_state: begin
        if (viol) begin
          next_state = fdi_pkg::search_state; // see RL4
          next_hits = fdi_pkg::CNT_RESET;
        end else if (hit) begin
          if (4'(hits + 1'b1) >= HIT_LIMIT) begin
            next_state = fdi_pkg::locked_state; // see RL3
            next_hits = fdi_pkg::CNT_RESET;
          end else begin
            next_hits = 4'(hits + 1'b1);
          end
        end
      end
      fdi_pkg::locked_state: begin
        if (hit) begin
          next_viols = fdi_pkg::CNT_RESET;
        end else if (viol) begin
          if (4'(viols + 1'b1) >= DROP_LIMIT) begin
            next_state = fdi_pkg::search_state; // see RL5
            next_viols = fdi_pkg::CNT_RESET;
          end else begin
            next_viols = 4'(viols + 1'b1);
          end
        end
      end
      default: begin
        next_state = fdi_pkg::search_state;
        next_hits = fdi_pkg::CNT_RESET;
        next_viols = fdi_pkg::CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= fdi_pkg::search_state; // see RL14
      hits <= fdi_pkg::CNT_RESET;
      viols <= fdi_pkg::CNT_RESET;
      frame_locked <= 1'b0;
      delin_state <= fdi_pkg::search_state;
    end else begin
      state <= next_state;
      hits <= next_hits;
      viols <= next_viols;
      frame_locked <= next_state == fdi_pkg::locked_state;
      delin_state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interleaver parameters
  // Computed combinationally then registered; a bad setting zeroes block length, depth and span
  // rather than feeding a fractional block to the de-interleaver.
  logic [4:0] next_block_len;
  logic [11:0] next_depth;
  logic [15:0] next_span;
  logic next_cfg_error;
  logic [3:0] shift;
  logic [11:0] blocks_x8;
  logic [3:0] frac;
  logic [7:0] quot;

  always_comb begin
    unique case (block_div)
      fdi_pkg::DIV_BY_4: shift = 4'd2;
      fdi_pkg::DIV_BY_8: shift = 4'd3;
      fdi_pkg::DIV_BY_16: shift = 4'd4;
      default: shift = 4'd0;
    endcase
    // Block length is S divided exactly // see RL7
    // Range is judged on the full quotient so a large S cannot wrap into range
    quot = codeword_len >> shift;
    next_block_len = 5'(quot);
    next_cfg_error = (shift == 4'd0) || depth_mult > 7'(fdi_pkg::MULT_MAX)
      || ((codeword_len & 8'((1 << shift) - 1)) != 8'h00)
      || quot < 8'h02 || quot > 8'h10;
    // Depth = M*I + 1 // see RL8
    next_depth = 12'(depth_mult) * 12'(next_block_len) + 12'h001;
    // Span = floor(t*I/S)*D; t*I/S is t >> shift here // see RL9
    blocks_x8 = 12'(fdi_pkg::RS_T);
    frac = 4'(blocks_x8 >> shift);
    // Longest repairable burst, reported as status // see RL10
    next_span = 16'(frac) * 16'(next_depth);
    if (next_cfg_error) begin
      next_block_len = 5'd0;
      next_depth = 12'h000;
      next_span = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      block_len <= 5'd0;
      depth_octets <= 12'h000;
      erasure_span <= 16'h0000;
      cfg_error <= 1'b0;
    end else begin
      block_len <= next_block_len;
      depth_octets <= next_depth;
      erasure_span <= next_span;
      cfg_error <= next_cfg_error;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // De-interleaver, branch k takes octet k of each block // see RL11
  fdi_deinterleave #(
    .MAX_I(16),
    .MEM_DEPTH(16384)
  ) u_deint (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .block_len(block_len),
    .depth_mult(depth_mult),
    .in_octet(rx_octet),
    .out_octet(dl_octet)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_search_to_tent: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL2
    state == fdi_pkg::search_state && hit |=> state == fdi_pkg::tentative_lock_state)
    else $error("search did not advance on hit");
  chk_viol_in_tent: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL4
    state == fdi_pkg::tentative_lock_state && viol |=> state == fdi_pkg::search_state)
    else $error("tentative lock survived a violation");
  chk_two_hits_lock: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL3
    state == fdi_pkg::tentative_lock_state && hit && hits == 4'h1
    |=> state == fdi_pkg::locked_state)
    else $error("lock not reached after two hits");
  chk_drop_lock: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL5
    state == fdi_pkg::locked_state && viol && viols == 4'(DROP_LIMIT - 1'b1)
    |=> state == fdi_pkg::search_state)
    else $error("lock kept after the violation limit");
  chk_keep_lock: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL6
    state == fdi_pkg::locked_state && viols < 4'(DROP_LIMIT - 1'b1)
    |=> state == fdi_pkg::locked_state)
    else $error("lock dropped early");
  chk_no_count_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL1
    !marker.at_expected |=> $stable(state))
    else $error("state moved without an expected marker");
  chk_lock_flag: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL14
    frame_locked == (state == fdi_pkg::locked_state))
    else $error("lock flag disagrees with state");
  chk_depth_calc: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL8
    !next_cfg_error |=> depth_octets == 12'($past(depth_mult) * block_len + 1))
    else $error("depth not M*I+1");
  chk_block_len: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    !next_cfg_error |=> 8'(block_len) << $past(shift) == $past(codeword_len))
    else $error("block length does not divide codeword");
  chk_span_calc: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL9
    !next_cfg_error |=> erasure_span == 16'((8 >> $past(shift)) * depth_octets))
    else $error("erasure span wrong");
  chk_branch_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL13
    rx_octet.valid && rx_octet.block_start |=> dl_octet.block_start)
    else $error("block start not on branch 0");

  cov_lock: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == fdi_pkg::tentative_lock_state ##1 state == fdi_pkg::locked_state);
  cov_drop: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == fdi_pkg::locked_state ##1 state == fdi_pkg::search_state);
  cov_tent_fail: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == fdi_pkg::tentative_lock_state && viol);

endmodule // fdi_frame_delin

// ### dv/fdi_line_model.sv
// Remote line transceiver model: marker observations and an interleaved octet stream.
// Assumes the bench changes its commands at the falling edge; fixed to I=2, M=1.
`timescale 1ns/100ps
module fdi_line_model (
  // Clock
  input wire logic ref_clk,
  // Bench commands: 0 idle, 1 hit, 2 violated, 3 stray syncword
  input wire logic [1:0] mark_cmd,
  input wire logic send_en,
  // Line side
  output fdi_pkg::fdi_marker_t marker,
  output fdi_pkg::fdi_octet_t rx_octet
);
  // Beat restarts at zero whenever sending stops, so the bench can reckon the data
  logic [7:0] beat = 8'h00;
  logic tog = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // Idle-command sync_found toggles so the design cannot lean on a settled value
  assign marker.at_expected = (mark_cmd == 2'h1) || (mark_cmd == 2'h2);
  assign marker.sync_found = (mark_cmd == 2'h0) ? tog : (mark_cmd != 2'h2);
  //////////////////////////////////////////////////////////////////////////////
  // Branch j is delayed M*I*j = 2j beats, so odd beats carry the octet of two beats back
  assign rx_octet.valid = send_en;
  assign rx_octet.block_start = send_en & ~beat[0];
  assign rx_octet.data = !send_en ? ~beat : (beat[0] ? beat - 8'h02 : beat);
  always @(posedge ref_clk) begin
    beat <= send_en ? beat + 8'h01 : 8'h00;
    tog <= ~tog;
  end
endmodule // fdi_line_model

// ### dv/tb.sv
// Self-checking bench for the frame delineation block and its de-interleaver.
// Assumes one 100 MHz clock; a second instance runs at a rate above 26 Mbit/s.
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] codeword_len = 8'h0008;
  logic [1:0] block_div = 2'h0;
  logic [6:0] depth_mult = 7'h01;
  logic [1:0] mark_cmd = 2'h0;
  logic send_en = 1'b0;
  fdi_pkg::fdi_marker_t marker;
  fdi_pkg::fdi_octet_t rx_octet;
  fdi_pkg::fdi_octet_t dl_octet;
  fdi_pkg::fdi_state_t delin_state;
  fdi_pkg::fdi_state_t hi_state;
  logic frame_locked;
  logic hi_locked;
  logic cfg_error;
  logic [4:0] block_len;
  logic [11:0] depth_octets;
  logic [15:0] erasure_span;
  int bad_count = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  fdi_line_model u_line (.ref_clk(ref_clk), .mark_cmd(mark_cmd), .send_en(send_en),
    .marker(marker), .rx_octet(rx_octet));
  fdi_frame_delin #(.LINE_RATE_KBPS(12960)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .codeword_len(codeword_len), .block_div(block_div), .depth_mult(depth_mult),
    .marker(marker), .rx_octet(rx_octet), .dl_octet(dl_octet), .frame_locked(frame_locked),
    .delin_state(delin_state), .block_len(block_len), .depth_octets(depth_octets),
    .erasure_span(erasure_span), .cfg_error(cfg_error));
  fdi_frame_delin #(.LINE_RATE_KBPS(27000)) u_hi (.ref_clk(ref_clk), .reset_n(reset_n),
    .codeword_len(codeword_len), .block_div(block_div), .depth_mult(depth_mult),
    .marker(marker), .rx_octet(rx_octet), .dl_octet(), .frame_locked(hi_locked),
    .delin_state(hi_state), .block_len(), .depth_octets(), .erasure_span(), .cfg_error());
  //////////////////////////////////////////////////////////////////////////////
  // One idle slot follows each burst, so back-to-back calls never clash
  task automatic mark(input logic [1:0] c, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      mark_cmd = c;
    end
    @(negedge ref_clk);
    mark_cmd = 2'h0;
  endtask
  task automatic st(input fdi_pkg::fdi_state_t e, input fdi_pkg::fdi_state_t h);
    `CHK("state", e, delin_state)
    `CHK("locked", e == fdi_pkg::locked_state, frame_locked)
    `CHK("hi_state", h, hi_state)
  endtask
  task automatic t_search;
    st(fdi_pkg::search_state, fdi_pkg::search_state);
    mark(2'h3, 3);
    mark(2'h2, 2);
    st(fdi_pkg::search_state, fdi_pkg::search_state);
    mark(2'h1, 1);
    st(fdi_pkg::tentative_lock_state, fdi_pkg::tentative_lock_state);
    mark(2'h2, 1);
    st(fdi_pkg::search_state, fdi_pkg::search_state);
    $display("test search done");
  endtask
  task automatic t_drop;
    mark(2'h1, 2);
    st(fdi_pkg::locked_state, fdi_pkg::locked_state);
    mark(2'h2, 5);
    mark(2'h1, 1);
    mark(2'h2, 5);
    st(fdi_pkg::locked_state, fdi_pkg::locked_state);
    mark(2'h2, 1);
    st(fdi_pkg::search_state, fdi_pkg::locked_state);
    mark(2'h2, 1);
    st(fdi_pkg::search_state, fdi_pkg::locked_state);
    mark(2'h2, 1);
    st(fdi_pkg::search_state, fdi_pkg::search_state);
    mark(2'h1, 2);
    st(fdi_pkg::locked_state, fdi_pkg::locked_state);
    reset_n = 1'b0;
    @(negedge ref_clk);
    st(fdi_pkg::search_state, fdi_pkg::search_state);
    reset_n = 1'b1;
    $display("test drop done");
  endtask
  task automatic t_cfg;
    int tbl[9][3] = '{'{64, 0, 64}, '{64, 1, 64}, '{64, 2, 0}, '{8, 1, 1}, '{64, 3, 1},
      '{64, 0, 65}, '{128, 0, 1}, '{136, 0, 1}, '{66, 0, 1}};
    int s, d, m, i, ok;
    foreach (tbl[k]) begin
      s = tbl[k][0];
      d = tbl[k][1];
      m = tbl[k][2];
      i = s >> (d + 2);
      ok = (d < 3) && (s % (4 << d) == 0) && (m <= fdi_pkg::MULT_MAX) && (i >= 2) && (i <= 16);
      @(negedge ref_clk);
      codeword_len = 8'(s);
      block_div = 2'(d);
      depth_mult = 7'(m);
      repeat (2) @(negedge ref_clk);
      `CHK("cfg_error", !ok, cfg_error)
      `CHK("block_len", 5'(ok ? i : 0), block_len)
      `CHK("depth", 12'(ok ? m * i + 1 : 0), depth_octets)
      `CHK("erasure", 16'(ok ? (fdi_pkg::RS_T * i / s) * (m * i + 1) : 0), erasure_span)
    end
    $display("test config done");
  endtask
  task automatic t_stream;
    @(negedge ref_clk);
    codeword_len = 8'h0008;
    block_div = fdi_pkg::DIV_BY_4;
    depth_mult = 7'h01;
    repeat (3) @(negedge ref_clk);
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      send_en = 1'b1;
      if (n >= 6) begin
        `CHK("dl_data", 8'(n - 3), dl_octet.data)
        `CHK("dl_start", 1'((n - 1) % 2 == 0), dl_octet.block_start)
        `CHK("dl_valid", 1'b1, dl_octet.valid)
      end
    end
    @(negedge ref_clk);
    send_en = 1'b0;
    @(negedge ref_clk);
    `CHK("dl_idle", 1'b0, dl_octet.valid)
    $display("test stream done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    t_search;
    t_drop;
    t_cfg;
    t_stream;
    end_of_test;
  end
  // The tests need well under 300 cycles; 2000 leaves ample margin
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule // tb
